/* File: hw/sfmr_consts.svh */
// Register offsets, field ranges and reset values of the mapped-read controller.
// Assumes a 32-bit APB with byte addresses on an 8-bit paddr.
`ifndef SFMR_CONSTS_SVH
`define SFMR_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define SFMR_OFF_CMD      8'h00
`define SFMR_OFF_OPT      8'h04
`define SFMR_OFF_PEN      8'h08
`define SFMR_OFF_DMY      8'h0c
`define SFMR_OFF_RATE     8'h10
`define SFMR_OFF_MAN      8'h14
`define SFMR_OFF_STAT     8'h18

// ==========================================================================
// Field ranges
`define SFMR_F_OPC        23:16
`define SFMR_F_OPC2       7:0
`define SFMR_F_OPW        31:30
`define SFMR_F_OP2W       27:26
`define SFMR_F_ADW        25:24
`define SFMR_F_OPTW       21:20
`define SFMR_F_RDW        17:16
`define SFMR_B_DMON       15
`define SFMR_B_OPON       14
`define SFMR_B_OP2ON      12
`define SFMR_F_ADSEL      11:8
`define SFMR_F_OPTSEL     7:4
`define SFMR_F_DMW        17:16
`define SFMR_F_DUMMY_CYCLE_COUNT      2:0
`define SFMR_F_DIV        15:8
`define SFMR_F_PRE        1:0
`define SFMR_F_MOPC       7:0
`define SFMR_F_MTX        15:8
`define SFMR_B_MSEND      16
`define SFMR_B_MREAD      17
`define SFMR_B_MSTART     31
`define SFMR_B_BUSY       0
`define SFMR_B_PEND       1
`define SFMR_F_STATE      6:4
`define SFMR_F_MRX        15:8
`define SFMR_F_LEVEL      19:16

// ==========================================================================
// Codes and reset values
`define SFMR_W2           2'b01
`define SFMR_W4           2'b10
`define SFMR_ADSEL_32     4'hf
`define SFMR_RST_CMD      32'h00eb_0000
`define SFMR_RST_OPT      32'h0000_0000
`define SFMR_RST_PEN      32'h0222_c780
`define SFMR_RST_DMY      32'h0000_0005
`define SFMR_RST_RATE     32'h0000_0100

`endif

/* File: hw/sfmr_pkg.sv */
// Types shared by the mapped-read controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sfmr_pkg;

  // Gray code along the frame path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_SECOND_OPCODE  = 3'b011,
    ST_ADDR  = 3'b010,
    ST_OPT   = 3'b110,
    ST_DUMMY = 3'b111,
    ST_DATA  = 3'b101,
    ST_DONE  = 3'b100
  } sfmr_state_e;

  typedef struct packed {
    logic [31:0] bits;
    logic [5:0]  cycles;
    logic [2:0]  lines;
    logic        drive;
    logic        sample;
  } sfmr_phase_s;

  typedef struct packed {
    logic [31:0] data;
    logic [31:0] addr;
  } sfmr_word_s;

endpackage : sfmr_pkg
`default_nettype wire

/* File: hw/sfmr_top.sv */
// Mapped-read path of a multi-line serial flash controller with APB registers.
// Assumes one clock clk; flash pins come from outside and are synchronised here.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sfmr_consts.svh"

module sfmr_top
  import sfmr_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        map_req_valid,
  input  wire logic [31:0] map_req_addr,
  output logic             map_req_ready,
  output logic             map_rd_valid,
  output sfmr_word_s       map_rd_data,
  input  wire logic        map_rd_ready,
  output logic             spi_sck,
  output logic             spi_cs_n,
  output logic [3:0]       spi_io_o,
  output logic [3:0]       spi_io_oe,
  input  wire logic [3:0]  spi_io_i
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  // ========================================================================
  // Functions
  function automatic logic [1:0] width_shift(input logic [1:0] code);
    case (code)
      `SFMR_W2: width_shift = 2'd1;
      `SFMR_W4: width_shift = 2'd2;
      default:  width_shift = 2'd0;
    endcase
  endfunction : width_shift

  function automatic logic [2:0] ord(input sfmr_state_e s);
    case (s)
      ST_CMD:   ord = 3'd1;
      ST_SECOND_OPCODE:  ord = 3'd2;
      ST_ADDR:  ord = 3'd3;
      ST_OPT:   ord = 3'd4;
      ST_DUMMY: ord = 3'd5;
      ST_DATA:  ord = 3'd6;
      ST_DONE:  ord = 3'd7;
      default:  ord = 3'd0;
    endcase
  endfunction : ord

  function automatic sfmr_state_e at_ord(input logic [2:0] i);
    case (i)
      3'd1:    at_ord = ST_CMD;
      3'd2:    at_ord = ST_SECOND_OPCODE;
      3'd3:    at_ord = ST_ADDR;
      3'd4:    at_ord = ST_OPT;
      3'd5:    at_ord = ST_DUMMY;
      3'd6:    at_ord = ST_DATA;
      default: at_ord = ST_DONE;
    endcase
  endfunction : at_ord

  // First enabled phase after cur
  function automatic sfmr_state_e next_after(input sfmr_state_e cur, input logic [5:0] en);
    sfmr_state_e r;
    r = ST_DONE;
    for (int i = 6; i >= 1; i--)
    begin
      if (en[i-1] && (3'(i) > ord(cur)))
        r = at_ord(3'(i));
    end
    next_after = r;
  endfunction : next_after

  // ========================================================================
  // Declarations
  logic [31:0]         cmd_q, opt_q, pen_q, dmy_q, rate_q, man_q, stat;
  logic                man_pend_q, man_run_q, man_lock, apb_wr, apb_setup;
  logic [7:0]          man_rx_q;
  sfmr_state_e         state_q, nxt_st;
  sfmr_phase_s         ph_q, nxt_ph;
  logic [5:0]          cyc_q, ph_ticks_q, nbits;
  logic [1:0]          sh;
  logic [31:0]         shreg_q, rx_q, rx_nxt, addr_q, addr_src;
  logic                cs_n_q, sck_q, tick, fall, launch, mode_man, room, push, pop;
  logic                data_done;
  logic [5:0]          en;
  logic [2:0]          opt_ones;
  logic [10:0]         hp_raw, hp, div_cnt_q;
  logic [3:0]          io_s1_q, io_s2_q, in_bits;
  sfmr_word_s          buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]    wptr_q, rptr_q;
  logic [PTR_W:0]      cnt_q;

  // ========================================================================
  // APB slave, zero wait states
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = psel && penable;
  assign man_lock  = man_pend_q || (state_q != ST_IDLE);

  always_comb
  begin
    stat                = '0;
    stat[`SFMR_B_BUSY]  = (state_q != ST_IDLE);
    stat[`SFMR_B_PEND]  = man_pend_q;
    stat[`SFMR_F_STATE] = state_q;
    stat[`SFMR_F_MRX]   = man_rx_q;
    stat[`SFMR_F_LEVEL] = 4'(cnt_q);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr <= 1'b0;
      case (paddr)
        `SFMR_OFF_CMD:  prdata <= cmd_q;
        `SFMR_OFF_OPT:  prdata <= opt_q;
        `SFMR_OFF_PEN:  prdata <= pen_q;
        `SFMR_OFF_DMY:  prdata <= dmy_q;
        `SFMR_OFF_RATE: prdata <= rate_q;
        `SFMR_OFF_MAN:  prdata <= man_q;
        `SFMR_OFF_STAT: prdata <= stat;
        default:
        begin
          prdata  <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Read-mode settings
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_q  <= `SFMR_RST_CMD;
      opt_q  <= `SFMR_RST_OPT;
      pen_q  <= `SFMR_RST_PEN;
      dmy_q  <= `SFMR_RST_DMY;
      rate_q <= `SFMR_RST_RATE;
      man_q  <= '0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `SFMR_OFF_CMD:  cmd_q  <= pwdata;
        `SFMR_OFF_OPT:  opt_q  <= pwdata;
        `SFMR_OFF_PEN:  pen_q  <= pwdata;
        `SFMR_OFF_DMY:  dmy_q  <= pwdata;
        `SFMR_OFF_RATE: rate_q <= pwdata;
        `SFMR_OFF_MAN:  if (!man_lock) man_q <= {1'b0, pwdata[30:0]};
        default:        ;
      endcase
    end
  end

  // Manual command request; a new start is ignored while one is pending or a frame runs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      man_pend_q <= 1'b0;
    else if (apb_wr && (paddr == `SFMR_OFF_MAN) && !man_lock && pwdata[`SFMR_B_MSTART])
      man_pend_q <= 1'b1;
    else if (launch && man_pend_q)
      man_pend_q <= 1'b0;
  end

  // ========================================================================
  // Serial clock divider
  assign hp_raw = {3'b000, rate_q[`SFMR_F_DIV]} << rate_q[`SFMR_F_PRE];
  assign hp     = (hp_raw == 11'h000) ? 11'h001 : hp_raw;
  assign tick   = (state_q != ST_IDLE) && (div_cnt_q == hp - 11'h001);
  assign fall   = tick && sck_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_cnt_q <= '0;
    else if ((state_q == ST_IDLE) || tick)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + 11'h001;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sck_q <= 1'b0;
    else if ((state_q == ST_IDLE) || (state_q == ST_DONE))
      sck_q <= 1'b0;
    else if (tick)
      sck_q <= !sck_q;
  end

  // ========================================================================
  // Frame sequencing
  assign room          = (cnt_q < (PTR_W+1)'(BUF_DEPTH));
  assign mode_man      = (state_q == ST_IDLE) ? man_pend_q : man_run_q;
  assign map_req_ready = (state_q == ST_IDLE) && !man_pend_q && room;
  assign launch        = (state_q == ST_IDLE) && (man_pend_q || (map_req_valid && room));
  assign addr_src      = (state_q == ST_IDLE) ? map_req_addr : addr_q;
  assign opt_ones      = {2'b00, pen_q[7]} + {2'b00, pen_q[6]}
                       + {2'b00, pen_q[5]} + {2'b00, pen_q[4]};
  assign en = mode_man ? {man_q[`SFMR_B_MREAD], 1'b0, man_q[`SFMR_B_MSEND], 3'b001}
            : {1'b1, pen_q[`SFMR_B_DMON], |pen_q[`SFMR_F_OPTSEL],
               |pen_q[`SFMR_F_ADSEL], pen_q[`SFMR_B_OP2ON], pen_q[`SFMR_B_OPON]};

  // Setup of the phase that follows the current one
  always_comb
  begin
    nxt_ph = '0;
    sh     = 2'd0;
    nbits  = 6'd0;
    nxt_st = next_after(state_q, en);
    case (nxt_st)
      ST_CMD:
      begin
        sh          = mode_man ? 2'd0 : width_shift(pen_q[`SFMR_F_OPW]);
        nbits       = 6'd8;
        nxt_ph.bits = {mode_man ? man_q[`SFMR_F_MOPC] : cmd_q[`SFMR_F_OPC], 24'h0};
      end
      ST_SECOND_OPCODE:
      begin
        sh          = width_shift(pen_q[`SFMR_F_OP2W]);
        nbits       = 6'd8;
        nxt_ph.bits = {cmd_q[`SFMR_F_OPC2], 24'h0};
      end
      ST_ADDR:
      begin
        sh = width_shift(pen_q[`SFMR_F_ADW]);
        if (pen_q[`SFMR_F_ADSEL] == `SFMR_ADSEL_32)
        begin
          nbits       = 6'd32;
          nxt_ph.bits = addr_src;
        end
        else
        begin
          nbits       = 6'd24;
          nxt_ph.bits = {addr_src[23:0], 8'h0};
        end
      end
      ST_OPT:
      begin
        if (mode_man)
        begin
          nbits       = 6'd8;
          nxt_ph.bits = {man_q[`SFMR_F_MTX], 24'h0};
        end
        else
        begin
          sh          = width_shift(pen_q[`SFMR_F_OPTW]);
          nbits       = {opt_ones, 3'b000};
          nxt_ph.bits = opt_q;
        end
      end
      ST_DUMMY:
      begin
        sh    = width_shift(dmy_q[`SFMR_F_DMW]);
        nbits = 6'({3'b000, dmy_q[`SFMR_F_DUMMY_CYCLE_COUNT]} + 6'd1) << sh;
      end
      ST_DATA:
      begin
        sh            = mode_man ? 2'd0 : width_shift(pen_q[`SFMR_F_RDW]);
        nbits         = mode_man ? 6'd8 : 6'd32;
        nxt_ph.sample = 1'b1;
      end
      default: ;
    endcase
    nxt_ph.drive  = (nxt_st != ST_DUMMY) && (nxt_st != ST_DATA) && (nxt_st != ST_DONE);
    nxt_ph.lines  = 3'b001 << sh;
    nxt_ph.cycles = nbits >> sh;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      ph_q    <= '0;
      cyc_q   <= '0;
      shreg_q <= '0;
      cs_n_q  <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (launch)
          begin
            state_q <= nxt_st;
            ph_q    <= nxt_ph;
            cyc_q   <= nxt_ph.cycles;
            shreg_q <= nxt_ph.bits;
            cs_n_q  <= 1'b0;
          end
        ST_DONE:
          if (tick)
          begin
            state_q <= ST_IDLE;
            cs_n_q  <= 1'b1;
          end
        default:
          if (fall)
          begin
            if (cyc_q == 6'd1)
            begin
              state_q <= nxt_st;
              ph_q    <= nxt_ph;
              cyc_q   <= nxt_ph.cycles;
              shreg_q <= nxt_ph.bits;
            end
            else
            begin
              cyc_q   <= cyc_q - 6'd1;
              shreg_q <= shreg_q << ph_q.lines;
            end
          end
      endcase
    end
  end

  // Frame ownership and address of the mapped read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      man_run_q <= 1'b0;
      addr_q    <= '0;
    end
    else if (launch)
    begin
      man_run_q <= man_pend_q;
      addr_q    <= map_req_addr;
    end
  end

  // Falling edges seen in the current phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ph_ticks_q <= '0;
    else if (launch || (fall && (cyc_q == 6'd1)))
      ph_ticks_q <= '0;
    else if (fall)
      ph_ticks_q <= ph_ticks_q + 6'd1;
  end

  // ========================================================================
  // Pins
  assign spi_sck   = sck_q;
  assign spi_cs_n  = cs_n_q;
  assign spi_io_o  = (ph_q.lines == 3'd4) ? shreg_q[31:28]
                   : (ph_q.lines == 3'd2) ? {2'b00, shreg_q[31:30]} : {3'b000, shreg_q[31]};
  assign spi_io_oe = (ph_q.drive && (state_q != ST_IDLE) && (state_q != ST_DONE))
                   ? ((ph_q.lines == 3'd4) ? 4'hf : (ph_q.lines == 3'd2) ? 4'h3 : 4'h1) : 4'h0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_s1_q <= '0;
      io_s2_q <= '0;
    end
    else
    begin
      io_s1_q <= spi_io_i;
      io_s2_q <= io_s1_q;
    end
  end

  // Capture at the end of each high half
  assign in_bits   = (ph_q.lines == 3'd4) ? io_s2_q
                   : (ph_q.lines == 3'd2) ? {2'b00, io_s2_q[1:0]} : {3'b000, io_s2_q[1]};
  assign rx_nxt    = (rx_q << ph_q.lines) | {28'h0, in_bits};
  assign data_done = (state_q == ST_DATA) && fall && (cyc_q == 6'd1);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_q     <= '0;
      man_rx_q <= '0;
    end
    else
    begin
      if (fall && ph_q.sample)
        rx_q <= rx_nxt;
      if (data_done && man_run_q)
        man_rx_q <= rx_nxt[7:0];
    end
  end

  // ========================================================================
  // Read word buffer, first flash byte in the low lane
  assign push         = data_done && !man_run_q;
  assign pop          = map_rd_valid && map_rd_ready;
  assign map_rd_valid = (cnt_q != '0);
  assign map_rd_data  = buf_mem[rptr_q];

  always_ff @(posedge clk)
  begin
    if (push)
      buf_mem[wptr_q] <= '{data: {rx_nxt[7:0], rx_nxt[15:8], rx_nxt[23:16], rx_nxt[31:24]},
                           addr: addr_q};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + PTR_W'(1);
      if (pop)
        rptr_q <= rptr_q + PTR_W'(1);
      if (push && !pop)
        cnt_q <= cnt_q + (PTR_W+1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (PTR_W+1)'(1);
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_last_fall(sfmr_state_e st);
    (state_q == st) && fall && (cyc_q == 6'd1);
  endsequence

  sequence s_enter(sfmr_state_e st);
    $changed(state_q) && (state_q == st) && !man_run_q;
  endsequence

  a_cs_frame: assert property ((state_q == ST_IDLE) == spi_cs_n)
    else $error("chip select does not match frame");
  a_cmd_code: assert property (s_enter(ST_CMD) |-> shreg_q[31:24] == cmd_q[`SFMR_F_OPC])
    else $error("command phase loaded wrong opcode");
  a_cmd_single: assert property ((state_q == ST_CMD) && !man_run_q
    && (pen_q[`SFMR_F_OPW] == 2'b00) |-> spi_io_oe == 4'h1)
    else $error("command not on a single line");
  a_addr_quad: assert property ((state_q == ST_ADDR)
    && (pen_q[`SFMR_F_ADW] == `SFMR_W4) |-> spi_io_oe == 4'hf)
    else $error("address not on four lines");
  a_opt_quad: assert property ((state_q == ST_OPT) && !man_run_q
    && (pen_q[`SFMR_F_OPTW] == `SFMR_W4) |-> spi_io_oe == 4'hf)
    else $error("option bytes not on four lines");
  a_data_quad: assert property (s_enter(ST_DATA) ##0 (pen_q[`SFMR_F_RDW] == `SFMR_W4)
    |-> (ph_q.lines == 3'd4) && (ph_q.cycles == 6'd8) && (spi_io_oe == 4'h0))
    else $error("read data not sampled on four lines");
  a_opt_byte3: assert property (s_enter(ST_OPT) ##0 (pen_q[`SFMR_F_OPTSEL] == 4'h8)
    |-> (shreg_q[31:24] == opt_q[31:24]) && (ph_q.cycles == (6'd8 >> ph_q.lines[2:1])))
    else $error("option phase not limited to byte 3");
  a_dummy_count: assert property (s_last_fall(ST_DUMMY)
    |-> ph_ticks_q == {3'b000, dmy_q[`SFMR_F_DUMMY_CYCLE_COUNT]})
    else $error("dummy cycle count wrong");
  a_addr_len: assert property (s_last_fall(ST_ADDR) ##0 !man_run_q
    |-> ((ph_ticks_q + 6'd1) * ph_q.lines) == ((pen_q[`SFMR_F_ADSEL] == `SFMR_ADSEL_32)
        ? 6'd32 : 6'd24))
    else $error("address length wrong");
  a_phase_order: assert property ($changed(state_q) && (state_q != ST_IDLE)
    && ($past(state_q) != ST_IDLE) |-> ord(state_q) > ord($past(state_q)))
    else $error("phase out of order");
  a_second_opcode_skip: assert property ((state_q == ST_SECOND_OPCODE) |-> !man_run_q && pen_q[`SFMR_B_OP2ON])
    else $error("second opcode issued while off");
  a_word_push: assert property (s_last_fall(ST_DATA) ##0 !man_run_q
    |=> map_rd_valid ##0 !spi_cs_n)
    else $error("read word not delivered");
  a_man_single: assert property ((state_q == ST_OPT) && man_run_q |-> spi_io_oe == 4'h1)
    else $error("manual write data not on one line");

endmodule : sfmr_top
`default_nettype wire

/* File: verif/sfmr_flash_model.sv */
// Serial flash stand-in that captures read frames and serves quad data.
// Assumes the frame layout 8 cmd, 6 addr, 2 opt, 6 dummy, 8 data clocks.
// Manual frames: 8 cmd clocks, then a written byte on io0 or a register byte on io1.
`timescale 1ns/1ps
`default_nettype none
module sfmr_flash_model
(
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic [3:0] spi_io_o,
  input  wire logic [3:0] spi_io_oe,
  output logic [3:0]      spi_io_i
);
  // ==========================
  // Frame capture
  logic [7:0]  cmd_q;
  logic [23:0] addr_q;
  logic [7:0]  opt_q;
  logic [7:0]  dbyte;
  logic [7:0]  ser_q;
  localparam logic [7:0] REG_BYTE = 8'h96; // Arbitrary register content
  logic        dmy_drv_q = 1'b0;
  int          rise_q = 0;
  int          fall_q = 0;
  int          last_q = 0;
  int          nib;

  initial spi_io_i = 4'h5;

  always @(negedge spi_cs_n)
  begin
    rise_q = 0;
    fall_q = 0;
  end

  // Released lines toggle so stale data never matches
  always @(posedge spi_cs_n)
  begin
    last_q = rise_q;
    spi_io_i = ~spi_io_i;
  end

  always @(posedge spi_sck)
  begin
    if (!spi_cs_n)
    begin
      if (rise_q < 8)
        cmd_q = {cmd_q[6:0], spi_io_o[0]};
      else if (rise_q < 14)
        addr_q = {addr_q[19:0], spi_io_o};
      else if (rise_q < 16)
        opt_q = {opt_q[3:0], spi_io_o};
      else if (rise_q < 22 && spi_io_oe != 4'h0)
        dmy_drv_q = 1'b1;
      if (rise_q >= 8 && rise_q < 16)
        ser_q = {ser_q[6:0], spi_io_o[0]};
      rise_q++;
    end
  end

  // ==========================
  // Data out, byte n = address low byte + n, high nibble first
  always @(negedge spi_sck)
  begin
    if (!spi_cs_n)
    begin
      fall_q++;
      nib = fall_q - 22;
      dbyte = addr_q[7:0] + 8'(nib / 2);
      if (nib >= 0 && nib < 8)
        spi_io_i = nib[0] ? dbyte[3:0] : dbyte[7:4];
      else if (fall_q >= 8 && fall_q < 16)
        spi_io_i = {2'b00, REG_BYTE[15 - fall_q], 1'b0};
      else
        spi_io_i = ~spi_io_i;
    end
  end
endmodule : sfmr_flash_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the mapped-read flash controller.
// Assumes the flash stand-in and a 160 ns serial clock (divider 16).
`timescale 1ns/1ps
`default_nettype none
`include "sfmr_consts.svh"
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module testbench
  import sfmr_pkg::*;
;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, map_req_valid = 1'b0, map_rd_ready = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, map_req_addr = 32'h0, prdata, rd;
  logic        pready, pslverr, perr, map_req_ready, map_rd_valid;
  logic        spi_sck, spi_cs_n;
  logic [3:0]  spi_io_o, spi_io_oe, spi_io_i;
  sfmr_word_s  map_rd_data;
  int          err_count = 0, n_checks = 0, cyc = 0;

  always #2.5 clk = ~clk;

  sfmr_top sfmr_top_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .map_req_valid, .map_req_addr,
    .map_req_ready, .map_rd_valid, .map_rd_data, .map_rd_ready, .spi_sck,
    .spi_cs_n, .spi_io_o, .spi_io_oe, .spi_io_i);

  sfmr_flash_model sfmr_flash_model_i (.spi_sck, .spi_cs_n, .spi_io_o,
    .spi_io_oe, .spi_io_i);

  // ==========================
  // Bus tasks
  task automatic end_of_test;
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic req(input logic [31:0] a);
    @(posedge clk);
    map_req_valid <= 1'b1;
    map_req_addr <= a;
    do @(negedge clk); while (map_req_ready !== 1'b1);
    @(posedge clk);
    map_req_valid <= 1'b0;
  endtask : req

  task automatic take(input logic [31:0] a);
    do @(negedge clk); while (map_rd_valid !== 1'b1);
    `CHK(map_rd_data.addr, a)
    `CHK(map_rd_data.data, {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]})
    @(posedge clk);
    map_rd_ready <= 1'b1;
    @(posedge clk);
    map_rd_ready <= 1'b0;
  endtask : take

  task automatic frame(input logic [31:0] a, input logic [7:0] op, input logic [7:0] ob);
    do @(negedge clk); while (spi_cs_n !== 1'b1);
    `CHK(sfmr_flash_model_i.cmd_q, op)
    `CHK(sfmr_flash_model_i.addr_q, a[23:0])
    `CHK(sfmr_flash_model_i.opt_q, ob)
    `CHK(sfmr_flash_model_i.dmy_drv_q, 1'b0)
    `CHK(sfmr_flash_model_i.last_q, 30)
  endtask : frame

  // ==========================
  // Scenarios
  task automatic s_regs;
    apb(1'b0, `SFMR_OFF_CMD, 32'h0);
    `CHK(rd, `SFMR_RST_CMD)
    apb(1'b0, `SFMR_OFF_OPT, 32'h0);
    `CHK(rd, `SFMR_RST_OPT)
    apb(1'b0, `SFMR_OFF_PEN, 32'h0);
    `CHK(rd, `SFMR_RST_PEN)
    apb(1'b0, `SFMR_OFF_DMY, 32'h0);
    `CHK(rd, `SFMR_RST_DMY)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({perr, rd}, 33'h1_0000_0000)
    apb(1'b1, `SFMR_OFF_RATE, 32'h0000_1000);
    apb(1'b0, `SFMR_OFF_RATE, 32'h0);
    `CHK(rd, 32'h0000_1000)
  endtask : s_regs

  task automatic s_single;
    req(32'h0012_3450);
    take(32'h0012_3450);
    frame(32'h0012_3450, 8'heb, 8'h00);
  endtask : s_single

  // Stalled consumer fills the buffer, then drains it
  task automatic s_buffer;
    apb(1'b1, `SFMR_OFF_CMD, 32'h003b_0000);
    apb(1'b1, `SFMR_OFF_OPT, 32'ha500_0000);
    req(32'h00ab_cd10);
    req(32'h0056_78f0);
    do apb(1'b0, `SFMR_OFF_STAT, 32'h0); while (rd[`SFMR_F_LEVEL] !== 4'h2);
    @(negedge clk);
    `CHK(map_req_ready, 1'b0)
    frame(32'h0056_78f0, 8'h3b, 8'ha5);
    take(32'h00ab_cd10);
    take(32'h0056_78f0);
    apb(1'b0, `SFMR_OFF_STAT, 32'h0);
    `CHK(rd[`SFMR_F_LEVEL], 4'h0)
  endtask : s_buffer

  // Manual frames: write enable, register write, register read
  localparam logic [7:0] WEN_OPC = 8'h5a; // Arbitrary opcodes
  localparam logic [7:0] WRS_OPC = 8'h3d;
  localparam logic [7:0] RDS_OPC = 8'h4e;

  task automatic man_run(input logic [31:0] d);
    apb(1'b1, `SFMR_OFF_MAN, d);
    do apb(1'b0, `SFMR_OFF_STAT, 32'h0); while (rd[1:0] !== 2'b00);
  endtask : man_run

  task automatic s_manual;
    man_run({1'b1, 23'h0, WEN_OPC});
    `CHK({sfmr_flash_model_i.cmd_q, 8'(sfmr_flash_model_i.last_q)}, {WEN_OPC, 8'd8})
    man_run({1'b1, 15'h0001, 8'h3c, WRS_OPC});
    `CHK({sfmr_flash_model_i.ser_q, 8'(sfmr_flash_model_i.last_q)}, {8'h3c, 8'd16})
    man_run({1'b1, 15'h0002, 8'h00, RDS_OPC});
    `CHK(rd[`SFMR_F_MRX], sfmr_flash_model_i.REG_BYTE)
    `CHK(sfmr_flash_model_i.cmd_q, RDS_OPC)
  endtask : s_manual

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    s_regs();
    s_single();
    s_buffer();
    s_manual();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
